//--- dv/pin_mode_properties.sv
// Purpose: Checks on the pin-function select block
// Assumes: Zero-wait APB, register at offset zero
// Notes: Bound from the bench top file
module pin_mode_properties (
    // Clock, reset, strap and APB
    input wire        pclk, presetn, pin4_strap, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [3:0]  pstrb,
    // Pin function controls
    input wire [7:0]  pin_alt_sel, pin_out_en, pin_in_en, pin_pullup_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pins whose field holds mode m
    function automatic [7:0] dec(input [15:0] v, input [1:0] m);
        for (int i = 0; i < 8; i++) dec[i] = (v[2*i+:2] == m);
    endfunction
    // Full-word write, then read setup and access
    sequence wr_s; psel && penable && pwrite && paddr == 12'h000 && pstrb == 4'hf; endsequence
    sequence rd_s; psel && !penable && !pwrite && paddr == 12'h000 ##1 penable; endsequence
    a_alt_decode: assert property (wr_s |=> pin_alt_sel == dec($past(pwdata[15:0]), 2'h0))
        else $error("alternate select wrong");
    a_out_decode: assert property (wr_s |=> pin_out_en == dec($past(pwdata[15:0]), 2'h1))
        else $error("output enable wrong");
    a_pullup_decode: assert property (wr_s |=> pin_pullup_en == dec($past(pwdata[15:0]), 2'h2))
        else $error("pull-up wrong");
    a_nopull_input: assert property (wr_s |=> (pin_in_en & ~pin_pullup_en) == dec($past(pwdata[15:0]), 2'h3))
        else $error("plain input wrong");
    a_one_function: assert property ((pin_alt_sel | pin_out_en | pin_in_en) == 8'hff
        && (pin_alt_sel & pin_out_en | pin_alt_sel & pin_in_en | pin_out_en & pin_in_en) == 8'h00) else $error("pin function clash");
    a_read_back: assert property ((wr_s ##2 rd_s) |-> prdata == {16'h0000, $past(pwdata[15:0], 3)})
        else $error("read back wrong");
    a_reset_strap: assert property ($rose(presetn) |=> pin_pullup_en == {3'h0, pin4_strap, 4'h0} && pin_out_en == 8'h00)
        else $error("reset value wrong");
    a_zero_wait: assert property (psel && !penable |=> pready && !pslverr)
        else $error("access phase not ready");
endmodule

//--- dv/tb_port_g_pin_mode_control.sv
// Purpose: Self-checking bench for the pin-function select block
// Assumes: 250 MHz pclk, APB master with idle cycle between transfers
// Notes: Register model is an integer updated per byte strobe
module tb_port_g_pin_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, pin4_strap = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h1c552b0d;
    logic [3:0]  pstrb = 4'h0;
    logic [7:0]  pin_alt_sel, pin_out_en, pin_in_en, pin_pullup_en;
    wire         pready, pslverr;
    int          bad_count = 0, comparisons = 0, model = 0;
    port_g_pin_mode_control port_g_pin_mode_control_i (.pclk, .presetn, .pin4_strap, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_alt_sel, .pin_out_en, .pin_in_en, .pin_pullup_en);
    // Clock
    always #2 pclk = ~pclk;
    function automatic logic [7:0] pick(input int v, input int m);
        for (int i = 0; i < 8; i++) pick[i] = ((v >> (2 * i)) & 3) == m;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk); {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge pclk); penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin bad_count++; disable main_seq.run_tests; end
        rd = prdata;
        check(pslverr, 1'b0);
        {psel, penable} <= 2'b00;
    endtask
    // Write, update model, read back and compare pins
    task wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1, a, d, s);
        if (a == 12'h000 && s[0]) model[7:0] = d[7:0];
        if (a == 12'h000 && s[1]) model[15:8] = d[15:8];
        apb(0, 12'h000, 32'h0, 4'h0);
        check(rd, model);
        check({pin_alt_sel, pin_out_en}, {pick(model, 0), pick(model, 1)});
        check({pin_pullup_en, pin_in_en & ~pin_pullup_en}, {pick(model, 2), pick(model, 3)});
        apb(0, 12'h004, 32'h0, 4'h0);
        check(rd, 32'h0);
    endtask
    // Reset with each strap value, mode table, random traffic
    initial begin : main_seq
        begin : run_tests
        for (int s = 1; s >= 0; s--) begin
            pin4_strap <= s[0];
            presetn <= 0;
            repeat (6) @(posedge pclk);
            presetn <= 1;
            @(posedge pclk);
            apb(0, 12'h000, 32'h0, 4'h0);
            check(rd, s << 9);
            model = s << 9;
            $display("Reset test done");
        end
        for (int m = 0; m < 4; m++) wr_rd(12'h000, {16'h0, {8{m[1:0]}}}, 4'hf);
        $display("Mode test done");
        repeat (24) begin
            lfsr = lfsr_next(lfsr);
            wr_rd({9'h0, lfsr[20], 2'h0}, lfsr, lfsr[27:24]);
        end
        $display("Random test done");
        end
        print_verdict;
    end
endmodule
bind port_g_pin_mode_control pin_mode_properties pin_mode_properties_i (.pclk, .presetn, .pin4_strap, .psel, .penable,
    .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .pin_alt_sel, .pin_out_en, .pin_in_en,
    .pin_pullup_en);

//--- logic/pin_mode_defines.vh
// Purpose: Constants for the port pin-function select block
// Assumes: APB slave, 32-bit data, one register word
// Notes:   Pin 4 upper mode bit reset value is a strap-selected option
`ifndef PIN_MODE_DEFINES_VH
`define PIN_MODE_DEFINES_VH
`define PGFS_OFFSET     12'h000
`define PGFS_WIDTH      16
`define PGFS_RESET      16'h0000
`define PIN4_HI_BIT     9
`define MODE_ALT        2'h0
`define MODE_OUT        2'h1
`define MODE_IN_PU      2'h2
`define MODE_IN_NOPU    2'h3
`define NUM_PINS        8
`endif

//--- logic/port_g_pin_mode_control.v
// Purpose: Pin-function select register for an eight-pin port, APB slave
// Assumes: Single clock pclk, asynchronous active-low presetn
// Notes:   Zero-wait APB slave; unmapped reads return zero, pslverr always low
`include "pin_mode_defines.vh"

// Behaviour
// - Sixteen-bit register, reads return last write
// - Two bits per pin, pin 7 highest
// - 00 alternate function, 01 port output
// - 10 input with pull-up on
// - 11 input with pull-up off
module port_g_pin_mode_control (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Strap selecting reset value of pin 4 upper mode bit
    input  wire        pin4_strap,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Per-pin function controls
    output wire [7:0]  pin_alt_sel,
    output wire [7:0]  pin_out_en,
    output wire [7:0]  pin_in_en,
    output wire [7:0]  pin_pullup_en
);

    // Mode register and its next value
    reg  [15:0] port_g_pin_function_select_ff;
    reg  [15:0] nxt_port_g_pin_function_select;

    // Read data held through the access phase
    reg  [31:0] prdata_ff;
    reg  [31:0] nxt_prdata;

    // Strap synchroniser and one-shot load window
    reg         strap_meta_ff;
    reg         strap_sync_ff;
    reg         strap_pending_ff;

    // Transfer response flags
    reg         pready_ff;
    reg         nxt_pready;
    reg         pslverr_ff;
    reg         nxt_pslverr;

    // APB phase and address decode
    wire        setup_ph;
    wire        access_ph;
    wire        hit;
    wire        wr_acc;
    wire        rd_setup;
    wire [1:0]  lane_wr;

    // Setup is the first cycle of a transfer, access the cycle that completes it
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;

    // Only one word is mapped; every other offset reads zero and ignores writes
    assign hit       = (paddr == `PGFS_OFFSET);
    assign wr_acc    = access_ph & pwrite & hit;
    assign rd_setup  = setup_ph & ~pwrite & hit;

    // Byte lanes 0 and 1 carry the low and high halves of the mode word
    assign lane_wr   = {2{wr_acc}} & pstrb[1:0];

    // Strap passes two flip-flops before use; they run through reset so
    // that the settled strap level is ready at the first edge after release
    always @(posedge pclk) begin
        strap_meta_ff <= pin4_strap;
        strap_sync_ff <= strap_meta_ff;
    end

    // Register write with byte strobes, strap load once after reset release
    always @* begin
        nxt_port_g_pin_function_select = port_g_pin_function_select_ff;
        if (strap_pending_ff) begin
            nxt_port_g_pin_function_select[`PIN4_HI_BIT] = strap_sync_ff;
        end
        if (lane_wr[0]) begin
            nxt_port_g_pin_function_select[7:0] = pwdata[7:0];
        end
        if (lane_wr[1]) begin
            nxt_port_g_pin_function_select[15:8] = pwdata[15:8];
        end
    end

    // Mode register and strap window
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_g_pin_function_select_ff <= `PGFS_RESET;
            strap_pending_ff              <= 1'b1;
        end else begin
            port_g_pin_function_select_ff <= nxt_port_g_pin_function_select;
            strap_pending_ff              <= 1'b0;
        end
    end

    // Read data registered in setup phase, held through access phase
    always @* begin
        nxt_prdata = 32'h00000000;
        if (rd_setup) begin
            nxt_prdata = {16'h0000, nxt_port_g_pin_function_select};
        end else if (access_ph) begin
            nxt_prdata = prdata_ff;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Transfer response: ready in every access phase, no error response
    always @* begin
        nxt_pready  = setup_ph;
        nxt_pslverr = 1'b0;
    end

    // Response flags registered so the bus sees them straight from flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // One decode cell per pin; each follows the next register value so the
    // pin controls change at the same edge as the register itself
    pin_mode_cell #(
        .MODE_W (2)
    ) pin7_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[15:14]),
        .alt_sel   (pin_alt_sel[7]),
        .out_en    (pin_out_en[7]),
        .in_en     (pin_in_en[7]),
        .pullup_en (pin_pullup_en[7])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin6_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[13:12]),
        .alt_sel   (pin_alt_sel[6]),
        .out_en    (pin_out_en[6]),
        .in_en     (pin_in_en[6]),
        .pullup_en (pin_pullup_en[6])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin5_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[11:10]),
        .alt_sel   (pin_alt_sel[5]),
        .out_en    (pin_out_en[5]),
        .in_en     (pin_in_en[5]),
        .pullup_en (pin_pullup_en[5])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin4_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[9:8]),
        .alt_sel   (pin_alt_sel[4]),
        .out_en    (pin_out_en[4]),
        .in_en     (pin_in_en[4]),
        .pullup_en (pin_pullup_en[4])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin3_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[7:6]),
        .alt_sel   (pin_alt_sel[3]),
        .out_en    (pin_out_en[3]),
        .in_en     (pin_in_en[3]),
        .pullup_en (pin_pullup_en[3])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin2_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[5:4]),
        .alt_sel   (pin_alt_sel[2]),
        .out_en    (pin_out_en[2]),
        .in_en     (pin_in_en[2]),
        .pullup_en (pin_pullup_en[2])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin1_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[3:2]),
        .alt_sel   (pin_alt_sel[1]),
        .out_en    (pin_out_en[1]),
        .in_en     (pin_in_en[1]),
        .pullup_en (pin_pullup_en[1])
    );

    pin_mode_cell #(
        .MODE_W (2)
    ) pin0_cell_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .mode      (nxt_port_g_pin_function_select[1:0]),
        .alt_sel   (pin_alt_sel[0]),
        .out_en    (pin_out_en[0]),
        .in_en     (pin_in_en[0]),
        .pullup_en (pin_pullup_en[0])
    );

    // Bus outputs come straight from their flip-flops
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

endmodule

// Per-pin decode: one two-bit mode field to four registered pin controls
module pin_mode_cell #(
    parameter MODE_W = 2
) (
    // Clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // Mode field of this pin
    input  wire [MODE_W-1:0] mode,
    // Registered pin controls
    output wire              alt_sel,
    output wire              out_en,
    output wire              in_en,
    output wire              pullup_en
);

    // Registered controls and their next values
    reg         alt_ff;
    reg         out_ff;
    reg         in_ff;
    reg         pu_ff;
    reg         nxt_alt;
    reg         nxt_out;
    reg         nxt_in;
    reg         nxt_pu;

    // Exactly one function per pin; the pull-up only ever goes with input
    always @* begin
        nxt_alt = 1'b0;
        nxt_out = 1'b0;
        nxt_in  = 1'b0;
        nxt_pu  = 1'b0;
        case (mode)
            `MODE_ALT: begin
                nxt_alt = 1'b1;
            end
            `MODE_OUT: begin
                nxt_out = 1'b1;
            end
            `MODE_IN_PU: begin
                nxt_in = 1'b1;
                nxt_pu = 1'b1;
            end
            default: begin
                nxt_in = 1'b1;
            end
        endcase
    end

    // Reset state matches an all-zero field: alternate function selected
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_ff <= 1'b1;
            out_ff <= 1'b0;
            in_ff  <= 1'b0;
            pu_ff  <= 1'b0;
        end else begin
            alt_ff <= nxt_alt;
            out_ff <= nxt_out;
            in_ff  <= nxt_in;
            pu_ff  <= nxt_pu;
        end
    end

    // Outputs straight from the flip-flops
    assign alt_sel   = alt_ff;
    assign out_en    = out_ff;
    assign in_en     = in_ff;
    assign pullup_en = pu_ff;

endmodule
